// [eecsc_engine_model.sv]
/*
  Array engine model: finishes each started operation after LAT cycles.
  Assumes op_start pulses only when the engine is idle.
*/
`timescale 1ns/1ps
`default_nettype none
module eecsc_engine_model #(
  parameter LAT = 20
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic op_start,
  input wire logic blank,
  output logic op_done,
  output logic op_verify_blank
);
  int cnt;
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 0;
      op_done <= 1'b0;
      op_verify_blank <= 1'b0;
    end else begin
      cnt <= op_start ? LAT : (cnt != 0 ? cnt - 1 : 0);
      op_done <= (cnt == 1);
      // only valid beside op_done, inverted otherwise
      op_verify_blank <= (cnt == 1) ? blank : !blank;
    end
  end
endmodule
`default_nettype wire

// [eecsc_regs.vh]
/*
  Register offsets, field positions, reset values and command codes
  for the EEPROM command and status controller.
  Assumes an 8-bit register port with byte offsets as printed.
*/
`ifndef EECSC_REGS_VH
`define EECSC_REGS_VH

`define EECSC_ADDR_W 4
`define EECSC_OFF_DIVIDER 4'h0
`define EECSC_OFF_IRQCFG 4'h3
`define EECSC_OFF_STATUS 4'h5
`define EECSC_OFF_CMD 4'h6
`define EECSC_OFF_RSVD3 4'h7

`define EECSC_ST_BEF 7
`define EECSC_ST_CCF 6
`define EECSC_ST_PVF 5
`define EECSC_ST_AEF 4
`define EECSC_ST_BLANK 2
`define EECSC_ST_FAIL 1
`define EECSC_ST_DONE 0

`define EECSC_CFG_BEIE 7
`define EECSC_CFG_COMMAND_COMPLETE_IRQ_ENABLE 6
`define EECSC_DIV_LOADED 7

`define EECSC_CMD_MASK 8'h65
`define EECSC_CMD_VERIFY 8'h05
`define EECSC_CMD_PROGRAM 8'h20
`define EECSC_CMD_SECT_ERASE 8'h40
`define EECSC_CMD_MASS_ERASE 8'h41
`define EECSC_CMD_SECT_MODIFY 8'h60

`define EECSC_RST_DIVIDER 7'h00
`define EECSC_RST_CMD 8'h00

`endif

// [eecsc_sva.sv]
/*
  Port checker for the EEPROM command and status controller.
  Assumes the register port and engine handshake of eecsc_top.
*/
`timescale 1ns/1ps
`default_nettype none
module eecsc_sva #(
  parameter ADDR_W = 4
) (
  input wire sys_clk,
  input wire resetn,
  input wire [ADDR_W-1:0] reg_addr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire special_mode,
  input wire op_start,
  input wire [7:0] op_cmd,
  input wire op_done,
  input wire cmd_complete_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  AST_RSVD_ZERO: assert property (reg_rd && reg_addr == 4'h7 |=>
    reg_rdata == 8'h00) else $error("reserved offset read nonzero");
  AST_CMD_BITS: assert property (reg_rd && reg_addr == 4'h6 |=>
    (reg_rdata & 8'h9A) == 8'h00) else $error("unused command bits set");
  AST_ST_BIT3: assert property (reg_rd && reg_addr == 4'h5 |=>
    !reg_rdata[3]) else $error("status bit 3 set");
  AST_ST_NORMAL: assert property (reg_rd && reg_addr == 4'h5 &&
    !special_mode |=> reg_rdata[1:0] == 2'h0) else $error("low bits set");
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  AST_CODE_OK: assert property (op_start |-> op_cmd inside
    {8'h05, 8'h20, 8'h40, 8'h41, 8'h60}) else $error("bad code started");
  AST_CC_CLEAR: assert property (op_start |=> !cmd_complete_irq)
    else $error("complete request while running");
  AST_NO_PULSE: assert property (op_done ##1 op_start |=>
    !cmd_complete_irq [*2]) else $error("complete pulsed on fetch");
endmodule
bind eecsc_top eecsc_sva #(.ADDR_W(ADDR_W)) eecsc_sva_i (
  .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .special_mode(special_mode),
  .op_start(op_start), .op_cmd(op_cmd), .op_done(op_done),
  .cmd_complete_irq(cmd_complete_irq));
`default_nettype wire

// [eecsc_top.v]
/*
  EEPROM command and status controller: command sequence tracking,
  two-stage command buffer, status flags and interrupt requests.
  Assumes a synchronous 8-bit register port, an array-write strobe
  from the bus decoder, and an array engine answering with op_done.
*/
// Behaviour
// - buffer empty flag bit 7, write-one launches, clears only if engine busy
// - zero write mid-sequence aborts, sets access error
// - zero write when idle does nothing
// - buffer empty with enable requests interrupt
// - complete flag bit 6, cleared on launch
// - no complete pulse when pending taken
// - complete flag read-only, enabled interrupt
// - protection violation bit 5, write-one clears
// - protection violation blocks launch
// - access error on sequence, code, stop
// - access error write-one clears, blocks launch
// - blank bit 2 on clean verify
// - special mode fail bit 1 clears by one
// - special mode done bit 0 shows idle
// - normal mode other bits read zero
// - command register keeps bits 6,5,2,0
// - five valid command codes accepted
// - other command codes set access error
// - reserved offset 7 reads zero
// - no execution before divider written
`timescale 1ns/1ps
`default_nettype none
`include "eecsc_regs.vh"

module eecsc_top #(
  parameter ADDR_W = `EECSC_ADDR_W
) (
  // clock and reset
  input wire sys_clk,
  input wire resetn,
  // register port
  input wire [ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // array side
  input wire array_word_wr,
  input wire array_protected,
  input wire special_mode,
  input wire cpu_stop,
  output reg op_start,
  output reg [7:0] op_cmd,
  input wire op_done,
  input wire op_verify_blank,
  // interrupts and divider
  output reg buf_empty_irq,
  output reg cmd_complete_irq,
  output reg [6:0] timebase_divider
);

  // sequence states
  localparam SEQ_IDLE = 3'b001;
  localparam SEQ_WORD = 3'b010;
  localparam SEQ_CMD = 3'b100;

  reg [2:0] seq_q;
  reg [2:0] seq_d;
  reg buffer_empty_flag_q;
  reg command_complete_flag_q;
  reg protection_violation_flag_q;
  reg access_error_flag_q;
  reg blank_q;
  reg fail_q;
  reg div_loaded_q;
  reg beie_q;
  reg command_complete_irq_enable_q;
  reg [7:0] command_code_q;
  reg pend_q;
  reg [7:0] pend_cmd_q;
  reg active_q;

  function is_valid_cmd;
    input [7:0] c;
    begin
      is_valid_cmd = (c == `EECSC_CMD_VERIFY) ||
        (c == `EECSC_CMD_PROGRAM) || (c == `EECSC_CMD_SECT_ERASE) ||
        (c == `EECSC_CMD_MASS_ERASE) || (c == `EECSC_CMD_SECT_MODIFY);
    end
  endfunction

  function is_prog_erase;
    input [7:0] c;
    begin
      is_prog_erase = (c != `EECSC_CMD_VERIFY);
    end
  endfunction

  wire wr_status = reg_wr && (reg_addr == `EECSC_OFF_STATUS);
  wire wr_cmd = reg_wr && (reg_addr == `EECSC_OFF_CMD);
  wire wr_cfg = reg_wr && (reg_addr == `EECSC_OFF_IRQCFG);
  wire wr_div = reg_wr && (reg_addr == `EECSC_OFF_DIVIDER);
  wire bef_one = wr_status && reg_wdata[`EECSC_ST_BEF];
  wire bef_zero = wr_status && !reg_wdata[`EECSC_ST_BEF];
  wire [7:0] cmd_masked = reg_wdata & `EECSC_CMD_MASK;
  wire errs = protection_violation_flag_q || access_error_flag_q;

  // launch attempt in the command step
  wire launch_try = bef_one && (seq_q == SEQ_CMD);
  // refused launches: errors pending or divider never written
  wire launch_ok = launch_try && !errs && div_loaded_q;
  wire launch_prot = launch_ok && is_prog_erase(command_code_q) &&
    array_protected;
  wire launch_go = launch_ok && !launch_prot;

  // sequence violations: out-of-order accesses abort the sequence
  wire bad_word = array_word_wr && (seq_q != SEQ_IDLE);
  wire bad_cmd = wr_cmd && (seq_q != SEQ_WORD);
  wire bad_code = wr_cmd && (seq_q == SEQ_WORD) &&
    !is_valid_cmd(cmd_masked);
  wire bad_launch = bef_one && (seq_q == SEQ_WORD);
  wire abort0 = bef_zero && (seq_q != SEQ_IDLE);
  wire bad_stop = cpu_stop && !command_complete_flag_q;
  wire set_acc = bad_word || bad_cmd || bad_code || bad_launch ||
    abort0 || bad_stop || (launch_try && !launch_ok && !errs);

  // engine slot: buffered command moves on when the active one ends
  wire fetch = pend_q && (!active_q || op_done);
  wire idle_next = !active_q || op_done;

  always @* begin
    seq_d = seq_q;
    case (seq_q)
      SEQ_IDLE: begin
        if (array_word_wr && buffer_empty_flag_q && !errs)
          seq_d = SEQ_WORD;
      end
      SEQ_WORD: begin
        if (wr_cmd && is_valid_cmd(cmd_masked))
          seq_d = SEQ_CMD;
        if (bad_word || bad_code || bad_launch || abort0)
          seq_d = SEQ_IDLE;
      end
      SEQ_CMD: begin
        if (bef_one || abort0 || bad_word || bad_cmd)
          seq_d = SEQ_IDLE;
      end
      default: seq_d = SEQ_IDLE;
    endcase
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      seq_q <= SEQ_IDLE;
      buffer_empty_flag_q <= 1'b1;
      command_complete_flag_q <= 1'b1;
      protection_violation_flag_q <= 1'b0;
      access_error_flag_q <= 1'b0;
      blank_q <= 1'b0;
      fail_q <= 1'b0;
      div_loaded_q <= 1'b0;
      beie_q <= 1'b0;
      command_complete_irq_enable_q <= 1'b0;
      command_code_q <= `EECSC_RST_CMD;
      pend_q <= 1'b0;
      pend_cmd_q <= `EECSC_RST_CMD;
      active_q <= 1'b0;
      op_start <= 1'b0;
      op_cmd <= `EECSC_RST_CMD;
      timebase_divider <= `EECSC_RST_DIVIDER;
      buf_empty_irq <= 1'b0;
      cmd_complete_irq <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      seq_q <= seq_d;
      op_start <= 1'b0;
      // divider is write-once after reset
      if (wr_div && !div_loaded_q) begin
        div_loaded_q <= 1'b1;
        timebase_divider <= reg_wdata[6:0];
      end
      if (wr_cfg) begin
        beie_q <= reg_wdata[`EECSC_CFG_BEIE];
        command_complete_irq_enable_q <= reg_wdata[`EECSC_CFG_COMMAND_COMPLETE_IRQ_ENABLE];
      end
      if (wr_cmd && seq_q == SEQ_WORD)
        command_code_q <= cmd_masked;
      // error flags: set beats a same-cycle clear
      if (launch_prot)
        protection_violation_flag_q <= 1'b1;
      else if (wr_status && reg_wdata[`EECSC_ST_PVF])
        protection_violation_flag_q <= 1'b0;
      if (set_acc)
        access_error_flag_q <= 1'b1;
      else if (wr_status && reg_wdata[`EECSC_ST_AEF])
        access_error_flag_q <= 1'b0;
      // buffer: launch loads pending slot while engine busy, else starts engine directly; fetch frees it
      if (launch_go) begin
        pend_q <= 1'b1;
        pend_cmd_q <= command_code_q;
        blank_q <= 1'b0;
      end else if (fetch) begin
        pend_q <= 1'b0;
      end
      // buffer is full only while a launched command waits for fetch
      if (launch_go && !fetch && active_q && !op_done)
        buffer_empty_flag_q <= 1'b0;
      else if (launch_go && pend_q && !fetch)
        buffer_empty_flag_q <= 1'b0;
      else if (fetch || (!pend_q && !launch_go))
        buffer_empty_flag_q <= 1'b1;
      if (fetch) begin
        active_q <= 1'b1;
        op_start <= 1'b1;
        op_cmd <= pend_cmd_q;
      end else if (op_done) begin
        active_q <= 1'b0;
      end
      if (launch_go && !pend_q && idle_next) begin
        active_q <= 1'b1;
        op_start <= 1'b1;
        op_cmd <= command_code_q;
        pend_q <= 1'b0;
      end
      // complete only when nothing active and nothing pending
      if (launch_go)
        command_complete_flag_q <= 1'b0;
      else if (op_done && !pend_q)
        command_complete_flag_q <= 1'b1;
      if (op_done && op_cmd == `EECSC_CMD_VERIFY) begin
        if (op_verify_blank)
          blank_q <= 1'b1;
        else if (special_mode)
          fail_q <= 1'b1;
      end else if (special_mode && wr_status &&
                   reg_wdata[`EECSC_ST_FAIL]) begin
        fail_q <= 1'b0;
      end
      buf_empty_irq <= beie_q && buffer_empty_flag_q;
      cmd_complete_irq <= command_complete_irq_enable_q && command_complete_flag_q;
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `EECSC_OFF_DIVIDER:
            reg_rdata <= {div_loaded_q, timebase_divider};
          `EECSC_OFF_IRQCFG:
            reg_rdata <= {beie_q, command_complete_irq_enable_q, 6'h00};
          `EECSC_OFF_STATUS:
            reg_rdata <= {buffer_empty_flag_q, command_complete_flag_q,
              protection_violation_flag_q, access_error_flag_q, 1'b0,
              blank_q, special_mode & fail_q,
              special_mode & !active_q};
          `EECSC_OFF_CMD:
            reg_rdata <= command_code_q;
          `EECSC_OFF_RSVD3:
            reg_rdata <= 8'h00;
          default:
            reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// [eecsc_top_tb.sv]
/*
  Self-checking bench for eecsc_top: a refused launch, register rows, then sequences.
  Assumes the engine model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module eecsc_top_tb;
  logic sys_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, array_word_wr = 0;
  logic array_protected = 0, special_mode = 0, cpu_stop = 0, blank = 1;
  logic [3:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata, op_cmd, last_cmd;
  logic op_start, op_done, op_verify_blank, buf_empty_irq, cmd_complete_irq;
  logic [6:0] div_seen;
  int n_errors = 0, checks = 0, starts = 0;
  logic [19:0] rows [5] = '{20'h7FF00, 20'h3FFC0, 20'h57FC0, 20'h00585,
    20'h00A85};
  logic [7:0] codes [5] = '{8'h20, 8'h40, 8'h41, 8'h60, 8'h05};
  always #10 sys_clk = ~sys_clk;
  eecsc_top eecsc_top_i (.sys_clk(sys_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .array_word_wr(array_word_wr),
    .array_protected(array_protected), .special_mode(special_mode),
    .cpu_stop(cpu_stop), .op_start(op_start), .op_cmd(op_cmd),
    .op_done(op_done), .op_verify_blank(op_verify_blank),
    .buf_empty_irq(buf_empty_irq), .cmd_complete_irq(cmd_complete_irq),
    .timebase_divider(div_seen));
  eecsc_engine_model eecsc_engine_model_i (.sys_clk(sys_clk),
    .resetn(resetn), .op_start(op_start), .blank(blank),
    .op_done(op_done), .op_verify_blank(op_verify_blank));
  always @(posedge sys_clk) if (op_start) begin
    starts++;
    last_cmd = op_cmd;
  end
  task summarize;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (e !== g) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1;
    @(posedge sys_clk);
    reg_wr <= 0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a; reg_rd <= 1;
    @(posedge sys_clk);
    reg_rd <= 0;
    @(negedge sys_clk);
    chk("read", e, reg_rdata);
  endtask
  task pulse_word;
    @(posedge sys_clk);
    array_word_wr <= 1;
    @(posedge sys_clk);
    array_word_wr <= 0;
  endtask
  task seq(input logic [7:0] c);
    pulse_word;
    wr(4'h6, c);
    wr(4'h5, 8'h80);
  endtask
  task wdone;
    int i;
    for (i = 0; i < 60 && op_done !== 1'b1; i++) @(negedge sys_clk);
    if (op_done !== 1'b1) begin
      n_errors++;
      summarize;
    end
    @(negedge sys_clk);
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    resetn <= 1;
    rd(4'h5, 8'hC0);
    seq(8'h20);
    rd(4'h5, 8'hD0);
    wr(4'h5, 8'h10);
    for (int r = 0; r < 5; r++) begin
      wr(rows[r][19:16], rows[r][15:8]);
      rd(rows[r][19:16], rows[r][7:0]);
    end
    chk("irqs", 8'h03, {6'h0, buf_empty_irq, cmd_complete_irq});
    chk("divider", 8'h05, {1'b0, div_seen});
    for (int k = 0; k < 5; k++) begin
      seq(codes[k]);
      wdone;
      chk("code", codes[k], last_cmd);
    end
    rd(4'h5, 8'hC4);
    seq(8'h20);
    seq(8'h40);
    rd(4'h5, 8'h00);
    wdone;
    wdone;
    rd(4'h5, 8'hC0);
    seq(8'h21);
    rd(4'h5, 8'hD0);
    wr(4'h5, 8'h10);
    pulse_word;
    wr(4'h5, 8'h00);
    rd(4'h5, 8'hD0);
    wr(4'h5, 8'h10);
    wr(4'h5, 8'h00);
    rd(4'h5, 8'hC0);
    array_protected <= 1;
    seq(8'h40);
    rd(4'h5, 8'hE0);
    array_protected <= 0;
    seq(8'h20);
    chk("starts", 8'd7, starts[7:0]);
    wr(4'h5, 8'h30);
    special_mode <= 1;
    rd(4'h5, 8'hC1);
    blank <= 0;
    seq(8'h05);
    rd(4'h5, 8'h80);
    wdone;
    rd(4'h5, 8'hC3);
    wr(4'h5, 8'h02);
    seq(8'h20);
    cpu_stop <= 1;
    @(posedge sys_clk);
    cpu_stop <= 0;
    wdone;
    rd(4'h5, 8'hD1);
    summarize;
  end
endmodule
`default_nettype wire
